/* rtl/fault_diag_pkg.sv */
// constants and types for the quad driver fault diagnosis block
package fault_diag_pkg;

  localparam int CHANNELS = 4;
  localparam int CODE_W   = 2;
  localparam int BYTE_W   = CHANNELS * CODE_W;
  localparam int CNT_W    = 16;

  // fault codes, numeric order equals priority
  localparam logic [CODE_W-1:0] CODE_NONE = 2'h0;
  localparam logic [CODE_W-1:0] CODE_OL   = 2'h1;
  localparam logic [CODE_W-1:0] CODE_SCG  = 2'h2;
  localparam logic [CODE_W-1:0] CODE_SCB  = 2'h3;

  // clock and filter times
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCB_FILTER_NS = 20000;
  localparam int SCG_FILTER_NS = 140000;
  localparam int OL_FILTER_NS  = 140000;
  localparam int CS_FILTER_NS  = 40;

  // least times round up, the chip select filter is a longest time and rounds down
  localparam int SCB_FILTER_CYCLES = (SCB_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCG_FILTER_CYCLES = (SCG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OL_FILTER_CYCLES  = (OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_FILTER_CYCLES  = (CS_FILTER_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                     (CS_FILTER_NS / CLK_PERIOD_NS);

  localparam logic [CNT_W-1:0] SCB_LIMIT = CNT_W'(SCB_FILTER_CYCLES);
  localparam logic [3:0]       CS_LIMIT  = 4'(CS_FILTER_CYCLES);

  // which condition the shared spike filter is timing
  typedef enum logic [1:0] {
    FILT_IDLE = 2'b00,
    FILT_SCG  = 2'b01,
    FILT_OL   = 2'b10
  } filter_kind_type;

endpackage : fault_diag_pkg

/* rtl/quad_driver_fault_diag_serial.sv */
// fault diagnosis, failure store and serial readout of the quad low-side switch
//
// Operation
// RULE_01 - priority: battery/overtemp over ground over open load
// RULE_02 - long overcurrent or overtemp switches channel off
// RULE_03 - restart needs on-control low then high again
// RULE_04 - overtemp per channel, only while stage on
// RULE_05 - overcurrent and overtemp share one fault code
// RULE_06 - ground short: low drain while off, filtered
// RULE_07 - ground filter started by control and detection
// RULE_08 - low current while on gives filtered open load
// RULE_09 - static open load stored at next control rise
// RULE_10 - sporadic open load stored at once
// RULE_11 - ground and open load share one filter
// RULE_12 - first shifted bit high when anything stored
// RULE_13 - chip select fall presents first bit
// RULE_14 - serial output released while chip select high
// RULE_15 - shift out on rise, capture in on fall
// RULE_16 - first clock rise copies store and clears it
// RULE_17 - store keeps catching faults during readout
// RULE_18 - master keeps clock low around select changes
// RULE_19 - chip select glitches cause no contention
// RULE_20 - undervoltage: stages off, store clear, output released
// RULE_21 - external reset low: same hold as undervoltage
// RULE_22 - undervoltage keeps every channel off regardless
// RULE_23 - four channel codes packed in one byte
// RULE_24 - two bits per channel, channel 3 highest
`timescale 1ns/1ns
`default_nettype none

module quad_driver_fault_diag_serial
  import fault_diag_pkg::*;
#(
  parameter int SCG_CYCLES = fault_diag_pkg::SCG_FILTER_CYCLES,
  parameter int OL_CYCLES  = fault_diag_pkg::OL_FILTER_CYCLES
)
(
  input  wire  logic                                mclk_i,
  input  wire  logic                                rst_i,
  input  wire  logic                                serial_clock_i,
  input  wire  logic                                chip_select_low_i,
  input  wire  logic                                serial_in_pin_i,
  output var   logic                                serial_out_pin_o,
  output var   logic                                serial_out_pin_oe_o,
  input  wire  logic [fault_diag_pkg::CHANNELS-1:0] channel_on_control_i,
  input  wire  logic [fault_diag_pkg::CHANNELS-1:0] overcurrent_i,
  input  wire  logic [fault_diag_pkg::CHANNELS-1:0] overtemp_i,
  input  wire  logic [fault_diag_pkg::CHANNELS-1:0] drain_low_i,
  input  wire  logic [fault_diag_pkg::CHANNELS-1:0] load_current_low_i,
  input  wire  logic                                open_load_sporadic_i,
  input  wire  logic                                supply_minimum_low_i,
  input  wire  logic                                external_reset_low_i,
  output var   logic [fault_diag_pkg::CHANNELS-1:0] stage_on_o,
  output var   logic [fault_diag_pkg::BYTE_W-1:0]   failure_store_o
);
  import fault_diag_pkg::*;

  localparam logic [CNT_W-1:0] SCG_LIMIT = CNT_W'(SCG_CYCLES);
  localparam logic [CNT_W-1:0] OL_LIMIT  = CNT_W'(OL_CYCLES);

  // global hold from supply and reset pin
  logic hold_meta;
  logic hold_sync;
  logic mode_meta;
  logic mode_sync;

  // link-side signals seen from the core clock
  logic                clear_toggle;
  logic                started;
  logic [BYTE_W-1:0]   shift_reg;
  logic                clr_meta;
  logic                clr_sync;
  logic                clr_prev;
  logic                clear_pulse;
  logic                st_meta;
  logic                st_sync;
  logic                bit_meta;
  logic                bit_sync;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {hold_sync, hold_meta}         <= 2'b11; // see RULE_20 see RULE_21
      {mode_sync, mode_meta}         <= 2'b00;
      {clr_prev, clr_sync, clr_meta} <= 3'b000;
      {st_sync, st_meta}             <= 2'b00;
      {bit_sync, bit_meta}           <= 2'b00;
    end
    else
    begin
      {hold_sync, hold_meta} <= {hold_meta, supply_minimum_low_i | ~external_reset_low_i};
      {mode_sync, mode_meta}         <= {mode_meta, open_load_sporadic_i};
      {clr_prev, clr_sync, clr_meta} <= {clr_sync, clr_meta, clear_toggle};
      {st_sync, st_meta}             <= {st_meta, started};
      {bit_sync, bit_meta}           <= {bit_meta, shift_reg[BYTE_W-1]};
    end
  end

  assign clear_pulse = clr_sync ^ clr_prev; // see RULE_16

  // per-channel detection and failure store
  logic [BYTE_W-1:0] store_byte;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      logic              on_meta;
      logic              on_sync;
      logic              on_prev;
      logic              oc_meta;
      logic              oc_sync;
      logic              ot_meta;
      logic              ot_sync;
      logic              dl_meta;
      logic              dl_sync;
      logic              lc_meta;
      logic              lc_sync;
      logic              latched_off;
      logic [CNT_W-1:0]  scb_count;
      logic              scb_event;
      filter_kind_type   kind;
      logic [CNT_W-1:0]  filt_count;
      logic              scg_event;
      logic              ol_event;
      logic              ol_pending;
      logic              ol_store;
      logic [CODE_W-1:0] new_code;
      logic [CODE_W-1:0] code;
      filter_kind_type   next_kind;

      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          {on_prev, on_sync, on_meta} <= 3'b000;
          {oc_sync, oc_meta}          <= 2'b00;
          {ot_sync, ot_meta}          <= 2'b00;
          {dl_sync, dl_meta}          <= 2'b00;
          {lc_sync, lc_meta}          <= 2'b00;
        end
        else
        begin
          {on_prev, on_sync, on_meta} <= {on_sync, on_meta, channel_on_control_i[ch]};
          {oc_sync, oc_meta}          <= {oc_meta, overcurrent_i[ch]};
          {ot_sync, ot_meta}          <= {ot_meta, overtemp_i[ch]};
          {dl_sync, dl_meta}          <= {dl_meta, drain_low_i[ch]};
          {lc_sync, lc_meta}          <= {lc_meta, load_current_low_i[ch]};
        end
      end

      // overcurrent filter; overtemp acts at once, only while the stage is on
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          scb_count <= '0;
        else if (stage_on_o[ch] && oc_sync && scb_count != SCB_LIMIT)
          scb_count <= scb_count + 1'b1;
        else if (!(stage_on_o[ch] && oc_sync))
          scb_count <= '0;
      end

      assign scb_event = stage_on_o[ch] &&
                         ((oc_sync && scb_count == SCB_LIMIT) || ot_sync); // see RULE_02 see RULE_04

      // a shutdown stays until the control input falls; the rise after re-enables
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          latched_off <= 1'b0;
        else if (scb_event)
          latched_off <= 1'b1; // see RULE_02
        else if (!on_sync)
          latched_off <= 1'b0; // see RULE_03
      end

      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          stage_on_o[ch] <= 1'b0;
        else
          stage_on_o[ch] <= on_sync && !latched_off && !scb_event && !hold_sync; // see RULE_22
      end

      // one spike filter serves both ground short and open load
      always_comb
      begin
        next_kind = FILT_IDLE;
        if (!on_sync && !on_prev && dl_sync)
          next_kind = FILT_SCG; // see RULE_06 see RULE_07
        else if (stage_on_o[ch] && lc_sync)
          next_kind = FILT_OL; // see RULE_08
      end

      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          kind       <= FILT_IDLE;
          filt_count <= '0;
        end
        else
        begin
          kind <= next_kind;
          case (next_kind)
            FILT_SCG:
              if (kind != FILT_SCG)
                filt_count <= '0;
              else if (filt_count != SCG_LIMIT)
                filt_count <= filt_count + 1'b1; // see RULE_11
            FILT_OL:
              if (kind != FILT_OL)
                filt_count <= '0;
              else if (filt_count != OL_LIMIT)
                filt_count <= filt_count + 1'b1; // see RULE_11
            default:
              filt_count <= '0;
          endcase
        end
      end

      // one event when the count first reaches its limit
      assign scg_event = kind == FILT_SCG && next_kind == FILT_SCG &&
                         filt_count == SCG_LIMIT - 1'b1;
      assign ol_event  = kind == FILT_OL && next_kind == FILT_OL &&
                         filt_count == OL_LIMIT - 1'b1;

      // static open load waits for the next control rise
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          ol_pending <= 1'b0;
        else if (hold_sync)
          ol_pending <= 1'b0;
        else if (ol_event && !mode_sync)
          ol_pending <= 1'b1;
        else if (on_sync && !on_prev)
          ol_pending <= 1'b0;
      end

      assign ol_store = (ol_event && mode_sync) || // see RULE_10
                        (ol_pending && on_sync && !on_prev); // see RULE_09

      always_comb
      begin
        new_code = CODE_NONE;
        if (scb_event)
          new_code = CODE_SCB; // see RULE_05
        else if (scg_event)
          new_code = CODE_SCG;
        else if (ol_store)
          new_code = CODE_OL;
      end

      // clear from the link loses nothing detected in the same cycle
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          code <= CODE_NONE;
        else if (hold_sync)
          code <= CODE_NONE; // see RULE_20 see RULE_21
        else if (clear_pulse)
          code <= new_code; // see RULE_16 see RULE_17
        else if (new_code > code)
          code <= new_code; // see RULE_01
      end

      assign store_byte[ch*CODE_W +: CODE_W] = code; // see RULE_23 see RULE_24
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      failure_store_o <= '0;
    else
      failure_store_o <= store_byte;
  end

  // chip select: synchronise, then demand a stable low before driving
  logic       cs_meta;
  logic       cs_sync;
  logic [3:0] cs_count;
  logic       cs_active;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
    end
    else
    begin
      cs_meta <= chip_select_low_i;
      cs_sync <= cs_meta;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      cs_count <= '0;
    else if (cs_sync)
      cs_count <= '0;
    else if (cs_count != CS_LIMIT)
      cs_count <= cs_count + 1'b1;
  end

  assign cs_active = !cs_sync && cs_count == CS_LIMIT; // see RULE_19

  // snapshot frozen while select is low, so the link clock reads a still word
  logic [BYTE_W-1:0] snapshot;
  logic              snapshot_any;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      snapshot     <= '0;
      snapshot_any <= 1'b0;
    end
    else if (cs_sync)
    begin
      snapshot     <= store_byte;
      snapshot_any <= |store_byte; // see RULE_12
    end
  end

  // output pin: release once the synchronised select is high, drive only after the filter
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      serial_out_pin_o    <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
    end
    else
    begin
      serial_out_pin_oe_o <= cs_active && !hold_sync; // see RULE_14 see RULE_20
      if (!cs_active)
        serial_out_pin_o <= 1'b0;
      else if (!st_sync)
        serial_out_pin_o <= snapshot_any; // see RULE_13
      else
        serial_out_pin_o <= bit_sync; // see RULE_15
    end
  end

  // link clock domain; a high select resets the frame asynchronously,
  // which is safe since the master keeps the clock low around it
  logic link_rst;
  logic in_bit;

  assign link_rst = rst_i | chip_select_low_i; // see RULE_18

  always_ff @(negedge serial_clock_i or posedge link_rst)
  begin
    if (link_rst)
      in_bit <= 1'b0;
    else
      in_bit <= serial_in_pin_i; // see RULE_15
  end

  always_ff @(posedge serial_clock_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      started   <= 1'b0;
      shift_reg <= '0;
    end
    else if (!started)
    begin
      started   <= 1'b1;
      shift_reg <= snapshot; // see RULE_16
    end
    else
      shift_reg <= {shift_reg[BYTE_W-2:0], in_bit}; // see RULE_15
  end

  // toggle outlives the frame so the core sees exactly one clear per read
  always_ff @(posedge serial_clock_i or posedge rst_i)
  begin
    if (rst_i)
      clear_toggle <= 1'b0;
    else if (!started && !chip_select_low_i)
      clear_toggle <= ~clear_toggle; // see RULE_16
  end

endmodule : quad_driver_fault_diag_serial

`default_nettype wire

/* tb/fault_diag_monitor.sv */
// concurrent checks on the fault diagnosis block ports
`timescale 1ns/1ns
`default_nettype none
module fault_diag_monitor
  import fault_diag_pkg::*;
(
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                chip_select_low_i,
  input wire logic                serial_out_pin_o,
  input wire logic                serial_out_pin_oe_o,
  input wire logic [CHANNELS-1:0] channel_on_control_i,
  input wire logic [CHANNELS-1:0] overtemp_i,
  input wire logic                supply_minimum_low_i,
  input wire logic                external_reset_low_i,
  input wire logic [CHANNELS-1:0] stage_on_o,
  input wire logic [BYTE_W-1:0]   failure_store_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_ext_hold;
    !external_reset_low_i [*5];
  endsequence
  sequence s_low_supply;
    supply_minimum_low_i [*5];
  endsequence
  sequence s_trip;
    |(overtemp_i & $past(stage_on_o) & ~stage_on_o);
  endsequence
  property p_ext_hold;
    s_ext_hold |-> stage_on_o == 4'h0 && failure_store_o == 8'h0 && !serial_out_pin_oe_o;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("hold under external reset lost");
  property p_low_supply;
    s_low_supply |-> stage_on_o == 4'h0 && failure_store_o == 8'h0 && !serial_out_pin_oe_o;
  endproperty
  a_low_supply: assert property (p_low_supply)
    else $error("hold under low supply lost");
  property p_ctrl_off;
    (stage_on_o & ~channel_on_control_i & ~$past(channel_on_control_i)
      & ~$past(channel_on_control_i, 3)) == 4'h0;
  endproperty
  a_ctrl_off: assert property (p_ctrl_off)
    else $error("stage on without on request");
  property p_overtemp_off;
    (stage_on_o & overtemp_i & $past(overtemp_i) & $past(overtemp_i, 3)) == 4'h0;
  endproperty
  a_overtemp_off: assert property (p_overtemp_off)
    else $error("stage kept on under overtemp");
  property p_trip_code;
    s_trip |-> ##[0:2] ((failure_store_o & {failure_store_o[6:0], 1'b0} & 8'hAA) != 8'h0);
  endproperty
  a_trip_code: assert property (p_trip_code)
    else $error("trip not stored as top code");
  property p_release;
    $rose(chip_select_low_i) |-> ##[1:4] !serial_out_pin_oe_o;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released after select high");
  property p_oe_rise;
    $rose(serial_out_pin_oe_o) |-> !chip_select_low_i && !$past(chip_select_low_i, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("output enabled by short select pulse");
  property p_flag;
    $rose(serial_out_pin_oe_o) && $stable(failure_store_o)
      |-> serial_out_pin_o == (failure_store_o != 8'h0);
  endproperty
  a_flag: assert property (p_flag)
    else $error("first bit does not match store");
endmodule : fault_diag_monitor
bind quad_driver_fault_diag_serial fault_diag_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
  .chip_select_low_i(chip_select_low_i), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_o(serial_out_pin_oe_o), .channel_on_control_i(channel_on_control_i),
  .overtemp_i(overtemp_i), .supply_minimum_low_i(supply_minimum_low_i),
  .external_reset_low_i(external_reset_low_i), .stage_on_o(stage_on_o),
  .failure_store_o(failure_store_o));
`default_nettype wire

/* tb/link_master.sv */
// serial link master reading the diagnostic frame
`timescale 1ns/1ns
`default_nettype none
module link_master
(
  output var  logic sclk_o,
  output var  logic cs_low_o,
  output var  logic sdi_o,
  input  wire logic sdo_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_low_o = 1'b1;
    sdi_o = 1'b1; // input pin has a pull-up
  end
  // 17 rises: flag, store byte, the echoed input byte, then a spare bit
  task automatic xfer(input logic [7:0] din, input int half, output logic [16:0] res);
    logic [17:0] s;
    #7;
    cs_low_o = 1'b0;
    #150;
    for (int i = 0; i < 17; i++)
    begin
      s[17-i] = sdo_i;
      sclk_o = 1'b1;
      #(half / 2);
      sdi_o = (i < 8) ? din[7-i] : ~sdi_o;
      #(half - half / 2);
      sclk_o = 1'b0;
      #(half);
    end
    s[0] = sdo_i;
    #150;
    cs_low_o = 1'b1;
    sdi_o = 1'b1;
    res = {s[17:9], s[8:1]};
  endtask : xfer
  task automatic glitch();
    #3;
    cs_low_o = 1'b0;
    #20;
    cs_low_o = 1'b1;
  endtask : glitch
endmodule : link_master
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the fault diagnosis block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fault_diag_pkg::*;
  typedef struct {string name; logic [16:0] exp; int kind;} note_type;
  logic            mclk = 1'b0;
  logic            rst = 1'b1;
  logic [3:0]      ctrl = 4'h0, oc = 4'h0, ot = 4'h0, dl = 4'h0, lcl = 4'h0;
  logic            spor = 1'b0, sup = 1'b0, ext_low = 1'b1, last_sdo = 1'b0;
  wire logic       sclk, cs_low, serial_in_pin, serial_out_pin, oe, sdo_line;
  wire logic [3:0] stage;
  wire logic [7:0] store;
  logic [16:0]     frame_seen, seen;
  logic [7:0]      din;
  note_type        notes[$];
  note_type        n;
  event            chk_ev;
  int              num_errors = 0, total_checks = 0, ch;
  always #5 mclk = ~mclk;
  quad_driver_fault_diag_serial #(.SCG_CYCLES(20), .OL_CYCLES(20)) DUT (.mclk_i(mclk),
    .rst_i(rst), .serial_clock_i(sclk), .chip_select_low_i(cs_low), .serial_in_pin_i(serial_in_pin),
    .serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(oe), .channel_on_control_i(ctrl),
    .overcurrent_i(oc), .overtemp_i(ot), .drain_low_i(dl), .load_current_low_i(lcl),
    .open_load_sporadic_i(spor), .supply_minimum_low_i(sup),
    .external_reset_low_i(ext_low), .stage_on_o(stage), .failure_store_o(store));
  link_master master (.sclk_o(sclk), .cs_low_o(cs_low), .sdi_o(serial_in_pin), .sdo_i(sdo_line));
  // a released line drifts, so no stale bit can pass as data
  always @(posedge mclk) if (oe) last_sdo <= serial_out_pin;
  assign sdo_line = oe ? serial_out_pin : ~last_sdo;
  function automatic logic [16:0] code_at(input int code, input int c);
    return 17'(code) << (2 * c);
  endfunction : code_at
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc
  task automatic chk(input string name, input logic [16:0] exp, input int kind);
    notes.push_back('{name, exp, kind});
    -> chk_ev;
  endtask : chk
  task automatic compare(input string name, input logic [16:0] seen_v, input logic [16:0] exp);
    total_checks++;
    if (seen_v !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen_v);
    end
  endtask : compare
  task automatic frame(input logic [16:0] st, input int half);
    din = 8'($urandom);
    master.xfer(din, half, frame_seen);
    chk("frame", {(st != 17'h0), st[7:0], din}, 2);
    cyc(4);
    chk("store", 17'h0, 1);
  endtask : frame
  task automatic toggle(input int c);
    ctrl[c] <= 1'b0;
    cyc(6);
    ctrl[c] <= 1'b1;
    cyc(8);
  endtask : toggle
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  always @(chk_ev)
  begin
    #1;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      seen = (n.kind == 0) ? 17'(stage) : (n.kind == 1) ? 17'(store) : frame_seen;
      compare(n.name, seen, n.exp);
    end
  end
  initial
  begin
    #200000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(27));
    ch = $urandom % 4;
    cyc(12);
    rst <= 1'b0;
    cyc(6);
    ctrl <= 4'hF;
    cyc(8);
    chk("stage", 17'hF, 0);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        ot[ch] <= 1'b1;
      else
        oc[ch] <= 1'b1;
      cyc(2020);
      chk("stage", 17'(4'hF & ~(4'h1 << ch)), 0);
      chk("store", code_at(3, ch), 1);
      ot <= 4'h0;
      oc <= 4'h0;
      cyc(8);
      chk("stage", 17'(4'hF & ~(4'h1 << ch)), 0);
      frame(code_at(3, ch), 24);
      toggle(ch);
      chk("stage", 17'hF, 0);
    end
    for (int k = 0; k < 2; k++)
    begin
      spor <= k[0];
      lcl[ch] <= 1'b1;
      cyc(40);
      chk("store", k ? code_at(1, ch) : 17'h0, 1);
      lcl[ch] <= 1'b0;
      toggle(ch);
      chk("store", code_at(1, ch), 1);
      frame(code_at(1, ch), 24);
    end
    lcl[ch] <= 1'b1;
    dl[ch] <= 1'b1;
    cyc(40);
    lcl[ch] <= 1'b0;
    chk("store", code_at(1, ch), 1);
    ctrl[ch] <= 1'b0;
    cyc(40);
    chk("store", code_at(2, ch), 1);
    dl[ch] <= 1'b0;
    ctrl[ch] <= 1'b1;
    cyc(8);
    ot[ch] <= 1'b1;
    cyc(6);
    ot[ch] <= 1'b0;
    toggle(ch);
    lcl[ch] <= 1'b1;
    cyc(40);
    chk("store", code_at(3, ch), 1);
    lcl[ch] <= 1'b0;
    cyc(4);
    frame(code_at(3, ch), 24);
    master.glitch();
    for (int k = 0; k < 2; k++)
    begin
      lcl <= 4'hF;
      cyc(40);
      chk("store", 17'h55, 1);
      lcl <= 4'h0;
      if (k == 0)
        ext_low <= 1'b0;
      else
        sup <= 1'b1;
      cyc(8);
      chk("stage", 17'h0, 0);
      chk("store", 17'h0, 1);
      ext_low <= 1'b1;
      sup <= 1'b0;
      cyc(8);
    end
    cyc(2);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
